// ===== core/dcrw_pkg.sv
// Shared constants and types for the disc read/write clock and ready timing block
// Summary of operation
// (RULE_01) The read/write clock output carries the track bit-rate clock while writing and the recovered one while reading.
// (RULE_02) Write data is encoded and written in step with the clock read back from the bit clock track.
// (RULE_03) Decoding uses an oscillator that follows the incoming data transitions, not the clock track.
// (RULE_04) The active-low track origin output asserts when the bit clock track shows a gap in its pulses.
// (RULE_05) The active-low sector clock output presents the pulses recorded on the sector clock track.
// (RULE_06) Every sector write starts with an erased stretch of at least half a bit cell before the first transition.
// (RULE_07) The controller starts reading a sector one bit cell after the point where writing of it starts.
// (RULE_08) The controller tolerates up to one bit cell of offset between sector clock and data head.
// (RULE_09) After power-on the unit shows not-ready for ten seconds and only then shows ready.
// (RULE_10) The full ready delay restarts on every power-on, however short the off time was.
// (RULE_11) Each press of the power button toggles the unit between on and off.
// (RULE_12) Signals marked as inverted are active low, resting high and going low when asserted.
// (RULE_13) The controller selects heads with Y lines 0, 1, 4, 5 together with X lines 0 to 7.
// (RULE_14) The recovered clock runs at twice bit rate, restarts at each sector and is phase-corrected at each transition.
// (RULE_15) Each sector opens with a sync bit of one before the data, and the decoder strips it before output.
// (RULE_16) The disc-ready output stays low through the power-on delay and rises when the delay completes.
package dcrw_pkg;
    localparam int SYS_PERIOD_NS = 4;
    localparam longint SYS_MHZ = 250;
    localparam longint SYS_HZ = SYS_MHZ * 64'd1000000;
    localparam int CELL_NS = 300;
    localparam int GAP_NS = 600;
    localparam longint READY_S = 10;
    localparam logic [63:0] READY_PROD = READY_S * SYS_HZ;
    localparam logic [31:0] READY_CYC_DEF = READY_PROD[31:0];
    localparam int CELL_CYC = CELL_NS / SYS_PERIOD_NS;
    localparam logic [5:0] HALF_CYC = 6'(CELL_CYC / 2);
    localparam logic [5:0] QTR_CYC = 6'(CELL_CYC / 4);
    localparam logic [7:0] GAP_CYC = 8'((GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
    // Synchronised inputs of the system domain
    localparam int IN_PWR = 0;
    localparam int IN_SEC = 1;
    localparam int IN_FLUX = 2;
    localparam int IN_RGATE = 3;
    localparam int IN_BRATE = 4;
    localparam int IN_WACT = 5;
    localparam int IN_N = 6;
    localparam logic [5:0] IN_RST = 6'h09;
    // Synchronised inputs of the bit clock domain
    localparam int WIN_GATE = 0;
    localparam int WIN_DATA = 1;
    localparam int WIN_RDY = 2;
    localparam logic [2:0] WIN_RST = 3'h1;
    typedef enum logic [2:0] {
        DCRW_RD_IDLE = 3'b001,
        DCRW_RD_SYNC = 3'b010,
        DCRW_RD_DATA = 3'b100
    } dcrw_rd_e;
    typedef enum logic [4:0] {
        DCRW_WR_IDLE = 5'b00001,
        DCRW_WR_ERASE = 5'b00010,
        DCRW_WR_SYNC = 5'b00100,
        DCRW_WR_MID = 5'b01000,
        DCRW_WR_END = 5'b10000
    } dcrw_wr_e;
endpackage

// ===== core/dcrw_bit_if.sv
// Carrier between the system-clock logic and the bit-clock write logic
`timescale 1ns/1ns
interface dcrw_bit_if;
    logic wr_active;
    logic bit_rate;
    logic unit_ready;
    modport sys (input wr_active, input bit_rate, output unit_ready);
    modport bit_side (output wr_active, output bit_rate, input unit_ready);
endinterface

// ===== core/dcrw_wenc.sv
// Write encoder running on the bit clock track
`timescale 1ns/1ns
module dcrw_wenc (
    input wire logic clk_bit,
    input wire logic rst,
    input wire logic write_gate_n,
    input wire logic write_data,
    output logic write_flux,
    output logic write_en,
    dcrw_bit_if.bit_side link
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] flt;
        dcrw_pkg::dcrw_wr_e st;
        logic bit_rate;
        logic flux;
        logic prev;
        logic dbit;
    } dcrw_wst_s;
    dcrw_wst_s q;
    dcrw_wst_s d;
    logic go;

    // One clock edge per half cell, so the bit-rate clock is this clock halved
    always_comb begin
        d = q;
        d.s1 = {link.unit_ready, write_data, write_gate_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.flt = ((q.s2 ~^ q.s3) & q.s2) | (~(q.s2 ~^ q.s3) & q.flt);
        d.bit_rate = ~q.bit_rate;
        go = !q.flt[dcrw_pkg::WIN_GATE] && q.flt[dcrw_pkg::WIN_RDY];
        case (q.st)
            dcrw_pkg::DCRW_WR_IDLE: begin
                if (go) begin
                    d.st = dcrw_pkg::DCRW_WR_ERASE;
                end
            end
            // Current on, no transition: old history is wiped for a whole cell
            dcrw_pkg::DCRW_WR_ERASE: begin
                d.st = dcrw_pkg::DCRW_WR_SYNC; // [RULE_06]
            end
            // Sync bit one: transition at end of its cell
            dcrw_pkg::DCRW_WR_SYNC: begin
                d.flux = ~q.flux; // [RULE_15]
                d.prev = 1'b1;
                d.st = dcrw_pkg::DCRW_WR_MID;
            end
            dcrw_pkg::DCRW_WR_MID: begin
                d.dbit = q.flt[dcrw_pkg::WIN_DATA];
                if (!q.flt[dcrw_pkg::WIN_DATA] && !q.prev) begin
                    d.flux = ~q.flux; // [RULE_02]
                end
                d.st = dcrw_pkg::DCRW_WR_END;
            end
            dcrw_pkg::DCRW_WR_END: begin
                if (q.dbit) begin
                    d.flux = ~q.flux; // [RULE_02]
                end
                d.prev = q.dbit;
                d.st = go ? dcrw_pkg::DCRW_WR_MID : dcrw_pkg::DCRW_WR_IDLE;
            end
            default: begin
                d.st = dcrw_pkg::DCRW_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_bit or posedge rst) begin
        if (rst) begin
            q <= '{s1: dcrw_pkg::WIN_RST, s2: dcrw_pkg::WIN_RST, s3: dcrw_pkg::WIN_RST,
                   flt: dcrw_pkg::WIN_RST, st: dcrw_pkg::DCRW_WR_IDLE, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign write_flux = q.flux;
    assign write_en = ~q.st[0]; // Idle bit alone, so the crossing sees no decode glitch
    assign link.wr_active = write_en;
    assign link.bit_rate = q.bit_rate;

    // Erase lasts a full cell before the sync transition
    a_erase_lead: assert property (@(posedge clk_bit) disable iff (rst) // [RULE_06]
        q.st == dcrw_pkg::DCRW_WR_ERASE |=> (q.st == dcrw_pkg::DCRW_WR_SYNC && $stable(write_flux))
        ##1 $changed(write_flux))
        else $error("write did not open with an erased stretch");
    a_enc_one: assert property (@(posedge clk_bit) disable iff (rst) // [RULE_02]
        (q.st == dcrw_pkg::DCRW_WR_END) |=> ($changed(write_flux) == $past(q.dbit)))
        else $error("one bit end transition wrong");
    a_enc_zero: assert property (@(posedge clk_bit) disable iff (rst) // [RULE_02]
        (q.st == dcrw_pkg::DCRW_WR_MID) |=> ($changed(write_flux) == ($past(!q.flt[1]) && $past(!q.prev))))
        else $error("zero bit mid transition wrong");
endmodule

// ===== core/dcrw_top.sv
// Clock source, track origin, sector clock, read decode and ready timing of the disc unit
`timescale 1ns/1ns
module dcrw_top #(
    parameter logic [31:0] READY_CYC = dcrw_pkg::READY_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_bit,
    input wire logic power_btn_n,
    input wire logic sector_track,
    input wire logic read_flux,
    input wire logic read_gate_n,
    input wire logic write_gate_n,
    input wire logic write_data,
    output logic rw_clk_n,
    output logic track_origin_n,
    output logic sector_clk_n,
    output logic clock_track_out,
    output logic disc_ready,
    output logic unit_on,
    output logic lamp_white,
    output logic lamp_green,
    output logic read_data,
    output logic read_strobe,
    output logic read_error,
    output logic write_flux,
    output logic write_en
);
    typedef struct packed {
        logic [dcrw_pkg::IN_N-1:0] s1;
        logic [dcrw_pkg::IN_N-1:0] s2;
        logic [dcrw_pkg::IN_N-1:0] s3;
        logic [dcrw_pkg::IN_N-1:0] flt;
        logic on;
        logic [31:0] rdy_cnt;
        logic ready;
        logic [7:0] gap_cnt;
        logic origin_n;
        logic sector_n;
        logic ct;
        logic rw_clk_n;
        dcrw_pkg::dcrw_rd_e rd;
        logic [5:0] vco;
        logic half_e;
        logic mid_seen;
        logic end_seen;
        logic prev;
        logic skip;
        logic rdata;
        logic rstb;
        logic rerr;
    } dcrw_sys_s;

    dcrw_sys_s q;
    dcrw_sys_s d;
    dcrw_bit_if link ();
    logic press;
    logic brate_chg;
    logic flux_edge;
    logic sec_start;
    logic reading;
    logic wrap;

    dcrw_wenc u_wenc (
        .clk_bit(clk_bit),
        .rst(rst),
        .write_gate_n(write_gate_n),
        .write_data(write_data),
        .write_flux(write_flux),
        .write_en(write_en),
        .link(link)
    );

    always_comb begin
        d = q;
        // Three-stage capture; a change counts once the last two stages agree
        d.s1 = {link.wr_active, link.bit_rate, read_gate_n, read_flux, sector_track, power_btn_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.flt = ((q.s2 ~^ q.s3) & q.s2) | (~(q.s2 ~^ q.s3) & q.flt);
        press = q.flt[dcrw_pkg::IN_PWR] && !d.flt[dcrw_pkg::IN_PWR];
        brate_chg = q.flt[dcrw_pkg::IN_BRATE] != d.flt[dcrw_pkg::IN_BRATE];
        flux_edge = q.flt[dcrw_pkg::IN_FLUX] != d.flt[dcrw_pkg::IN_FLUX];
        sec_start = !q.flt[dcrw_pkg::IN_SEC] && d.flt[dcrw_pkg::IN_SEC];
        wrap = 1'b0;

        // Power toggle and ready delay; the count starts from zero on every turn-on
        if (press) begin
            d.on = ~q.on; // [RULE_11]
            d.rdy_cnt = 32'h0; // [RULE_10]
            d.ready = 1'b0;
        end else if (!q.on) begin
            d.rdy_cnt = 32'h0;
            d.ready = 1'b0;
        end else begin
            if (q.rdy_cnt != READY_CYC) begin
                d.rdy_cnt = q.rdy_cnt + 32'h1; // [RULE_09]
            end
            d.ready = (d.rdy_cnt == READY_CYC); // [RULE_16]
        end
        reading = q.on && q.ready && !q.flt[dcrw_pkg::IN_RGATE] && !q.flt[dcrw_pkg::IN_WACT];

        // Gap watch on the clock track; saturating so a stopped disc holds the origin low
        if (brate_chg) begin
            d.gap_cnt = 8'h0;
        end else if (q.gap_cnt != dcrw_pkg::GAP_CYC) begin
            d.gap_cnt = q.gap_cnt + 8'h1;
        end
        d.origin_n = !(d.gap_cnt == dcrw_pkg::GAP_CYC); // [RULE_04] [RULE_12]
        d.sector_n = !q.flt[dcrw_pkg::IN_SEC]; // [RULE_05] [RULE_12]
        d.ct = q.flt[dcrw_pkg::IN_BRATE];

        // Recovered oscillator: one window per half cell, transition re-centres it
        d.rstb = 1'b0;
        case (q.rd)
            dcrw_pkg::DCRW_RD_IDLE: begin
                if (reading) begin
                    d.rd = dcrw_pkg::DCRW_RD_SYNC;
                    d.vco = 6'h0;
                end
            end
            dcrw_pkg::DCRW_RD_SYNC: begin
                d.vco = (q.vco == dcrw_pkg::HALF_CYC - 6'h1) ? 6'h0 : q.vco + 6'h1;
                if (flux_edge) begin
                    // First transition closes the sync cell
                    d.vco = dcrw_pkg::QTR_CYC; // [RULE_14]
                    d.half_e = 1'b1;
                    d.end_seen = 1'b1;
                    d.mid_seen = 1'b0;
                    d.prev = 1'b1;
                    d.skip = 1'b1; // [RULE_15]
                    d.rd = dcrw_pkg::DCRW_RD_DATA;
                end
            end
            dcrw_pkg::DCRW_RD_DATA: begin
                if (flux_edge) begin
                    d.vco = dcrw_pkg::QTR_CYC; // [RULE_03] [RULE_14]
                    if (q.half_e) begin
                        d.end_seen = 1'b1;
                    end else begin
                        d.mid_seen = 1'b1;
                    end
                end else if (q.vco == dcrw_pkg::HALF_CYC - 6'h1) begin
                    wrap = 1'b1;
                    d.vco = 6'h0;
                end else begin
                    d.vco = q.vco + 6'h1;
                end
                if (wrap) begin
                    d.half_e = ~q.half_e;
                    if (q.half_e) begin
                        // End window closed: decide the cell from where the transition fell
                        d.mid_seen = 1'b0;
                        d.end_seen = 1'b0;
                        d.skip = 1'b0;
                        if (q.skip) begin
                            d.prev = 1'b1; // [RULE_15]
                        end else begin
                            d.rdata = q.end_seen;
                            d.rstb = 1'b1;
                            d.rerr = (q.mid_seen && q.end_seen) || (q.mid_seen && q.prev) ||
                                     (!q.mid_seen && !q.end_seen && !q.prev);
                            d.prev = q.end_seen;
                        end
                    end
                end
            end
            default: begin
                d.rd = dcrw_pkg::DCRW_RD_IDLE;
            end
        endcase
        // A new sector restarts the oscillator; dropping read returns to idle
        if (!reading) begin
            d.rd = dcrw_pkg::DCRW_RD_IDLE;
            d.rstb = 1'b0;
        end else if (sec_start) begin
            d.rd = dcrw_pkg::DCRW_RD_SYNC; // [RULE_14]
            d.vco = 6'h0;
            d.mid_seen = 1'b0;
            d.end_seen = 1'b0;
            d.rstb = 1'b0;
        end

        // Clock source select; idle high so the controller sees no edge
        if (q.flt[dcrw_pkg::IN_WACT]) begin
            d.rw_clk_n = !q.flt[dcrw_pkg::IN_BRATE]; // [RULE_01]
        end else if (q.rd == dcrw_pkg::DCRW_RD_DATA) begin
            d.rw_clk_n = !q.half_e; // [RULE_01]
        end else begin
            d.rw_clk_n = 1'b1; // [RULE_12]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{s1: dcrw_pkg::IN_RST, s2: dcrw_pkg::IN_RST, s3: dcrw_pkg::IN_RST,
                   flt: dcrw_pkg::IN_RST, origin_n: 1'b1, sector_n: 1'b1, rw_clk_n: 1'b1,
                   rd: dcrw_pkg::DCRW_RD_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // Ready crosses into the bit clock domain through that side's capture stages
    assign link.unit_ready = q.on && q.ready;
    assign rw_clk_n = q.rw_clk_n;
    assign track_origin_n = q.origin_n;
    assign sector_clk_n = q.sector_n;
    assign clock_track_out = q.ct;
    assign disc_ready = q.on && q.ready;
    assign unit_on = q.on;
    // Lamp drive is a plain decode; white until the disc is up to speed
    assign lamp_white = q.on && !q.ready;
    assign lamp_green = q.on && q.ready;
    assign read_data = q.rdata;
    assign read_strobe = q.rstb;
    assign read_error = q.rerr;

    a_ready_delay: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_09]
        $rose(disc_ready) |-> (q.rdy_cnt == READY_CYC) && $past(q.rdy_cnt) == READY_CYC - 32'h1)
        else $error("ready rose before the delay ran out");
    a_ready_restart: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_10]
        $rose(unit_on) |-> (q.rdy_cnt == 32'h0) && !disc_ready ##1 !disc_ready)
        else $error("ready delay did not restart at turn-on");
    a_power_toggle: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_11]
        (q.flt[0] && !d.flt[0]) |=> (unit_on != $past(unit_on)))
        else $error("power press did not toggle the unit");
    a_origin_gap: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_04]
        !track_origin_n |-> (q.gap_cnt == dcrw_pkg::GAP_CYC) && $stable(q.flt[4]))
        else $error("track origin without a clock gap");
    a_sector_follow: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_05]
        ##1 (sector_clk_n == !$past(q.flt[1])))
        else $error("sector clock output does not follow the track");
    a_rwclk_write: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_01]
        q.flt[5] |=> (rw_clk_n == !$past(q.flt[4])))
        else $error("write clock not taken from the clock track");
    a_vco_restart: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_14]
        (reading && sec_start) |=> (q.vco == 6'h0) && (q.rd == dcrw_pkg::DCRW_RD_SYNC))
        else $error("oscillator not restarted at sector start");
    a_sync_strip: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_15]
        (q.rd == dcrw_pkg::DCRW_RD_DATA) && q.skip && wrap |=> !read_strobe)
        else $error("sync bit reached the data output");
    a_ready_out: assert property (@(posedge clk_sys) disable iff (rst) // [RULE_16]
        disc_ready |-> unit_on && (q.rdy_cnt == READY_CYC))
        else $error("disc ready asserted during the delay");
endmodule

// ===== tb/dcrw_ctrl_model.sv
// Controller-side model that requests one sector write on the track clock
`timescale 1ns/1ns
module dcrw_ctrl_model (
    input wire logic clk_bit,
    input wire logic rst,
    input wire logic go,
    input wire logic value,
    input wire logic [7:0] cells,
    output logic write_gate_n,
    output logic write_data
);
    // One frame per go; signals move just after a track clock edge
    // Only one track is addressed, head selection stays with the controller
    initial begin
        write_gate_n = 1'b1;
        write_data = 1'b0;
        forever begin
            @(posedge clk_bit);
            if (go && !rst) begin
                #1 write_data = value;
                repeat (4) @(posedge clk_bit);
                #1 write_gate_n = 1'b0; // Active-low request
                repeat (2 * cells) @(posedge clk_bit);
                #1 write_gate_n = 1'b1;
                // Data held past the last sampled cell, then no longer meaningful
                repeat (4) @(posedge clk_bit);
                #1 write_data = ~value;
            end
        end
    end
endmodule

// ===== tb/dcrw_top_test.sv
// Self-checking bench of the disc clock source and ready timing block
`timescale 1ns/1ns
module dcrw_top_test;
    localparam logic [31:0] RDY = 32'h000000c8;
    logic clk_sys = 1'b0, clk_bit = 1'b0, rst = 1'b1, bit_run = 1'b1, wr_go = 1'b0, wr_val = 1'b0;
    logic power_btn_n = 1'b1, sector_track = 1'b0, read_flux = 1'b0, read_gate_n = 1'b1;
    logic write_gate_n, write_data, rw_clk_n, track_origin_n, sector_clk_n, clock_track_out, disc_ready;
    logic unit_on, lamp_white, lamp_green, read_data, read_strobe, read_error, write_flux, write_en;
    logic last_flux, last_rw, last_ct;
    logic [31:0] seed = 32'h189c5b73;
    logic rq[$], eq[$];
    int wq[$];
    int failures = 0, n_compared = 0, cyc = 0, widx = 0, rw_tg = 0, ct_tg = 0;

    // System clock, 4 ns
    always #2 clk_sys = ~clk_sys;
    // Track clock, 15 ns, unrelated phase; stopped to fake the origin gap
    initial begin
        #3;
        forever begin
            #7 clk_bit = bit_run ? ~clk_bit : clk_bit;
            #8 clk_bit = bit_run ? ~clk_bit : clk_bit;
        end
    end

    dcrw_top #(.READY_CYC(RDY)) dcrw_top_i (.clk_sys(clk_sys), .rst(rst), .clk_bit(clk_bit),
        .power_btn_n(power_btn_n), .sector_track(sector_track), .read_flux(read_flux),
        .read_gate_n(read_gate_n), .write_gate_n(write_gate_n), .write_data(write_data),
        .rw_clk_n(rw_clk_n), .track_origin_n(track_origin_n), .sector_clk_n(sector_clk_n),
        .clock_track_out(clock_track_out), .disc_ready(disc_ready), .unit_on(unit_on),
        .lamp_white(lamp_white), .lamp_green(lamp_green), .read_data(read_data),
        .read_strobe(read_strobe), .read_error(read_error), .write_flux(write_flux), .write_en(write_en));
    dcrw_ctrl_model dcrw_ctrl_model_i (.clk_bit(clk_bit), .rst(rst), .go(wr_go), .value(wr_val),
        .cells(8'h08), .write_gate_n(write_gate_n), .write_data(write_data));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Hang guard, well above the expected few thousand cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            failures++;
            summarize();
        end
    end

    // Write flux changes indexed by track edges since write current came on
    always @(negedge clk_bit) begin
        if (write_en === 1'b1) begin
            if (write_flux !== last_flux) wq.push_back(widx);
            widx++;
        end
        last_flux = write_flux;
    end

    // Clock toggles and decoded bits, sampled away from the active edge
    always @(negedge clk_sys) begin
        if (rw_clk_n !== last_rw && (write_en === 1'b1 || read_gate_n === 1'b0)) rw_tg++;
        if (clock_track_out !== last_ct && write_en === 1'b1) ct_tg++;
        if (read_strobe === 1'b1) begin
            rq.push_back(read_data);
            eq.push_back(read_error);
        end
        last_rw = rw_clk_n;
        last_ct = clock_track_out;
    end

    // Press while off and time the whole ready delay from the power-on edge
    task automatic power_on();
        int n;
        n = 0;
        power_btn_n = 1'b0;
        while (unit_on !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("unit_on", unit_on, 1);
        check("lamps not ready", {lamp_green, lamp_white, disc_ready}, 3'b010);
        n = 0;
        while (disc_ready !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
            if (n == 5) power_btn_n = 1'b1;
        end
        check("ready delay", n, RDY);
        check("lamps ready", {lamp_green, lamp_white}, 2'b10);
        $display("power on test done");
    endtask

    task automatic power_off();
        power_btn_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        power_btn_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        check("off state", {unit_on, disc_ready, lamp_green, lamp_white}, 4'h0);
        $display("power off test done");
    endtask

    // Controller writes one constant-valued frame; monitors collect the result
    task automatic run_write(input logic v);
        int n;
        n = 0;
        wq.delete();
        widx = 0;
        rw_tg = 0;
        ct_tg = 0;
        wr_val = v;
        wr_go = 1'b1;
        while (write_gate_n !== 1'b0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        wr_go = 1'b0;
        while (write_gate_n !== 1'b1 && n < 250) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (60) @(negedge clk_sys);
    endtask

    // Modified NRZ: sync one ends at edge 2, then mid/end edges 2k+1, 2k+2
    task automatic check_write(input logic v);
        int exp[$];
        logic prev;
        prev = 1'b1;
        exp.push_back(2);
        for (int k = 1; k < 6; k++) begin
            if (v) exp.push_back(2 * k + 2);
            else if (!prev) exp.push_back(2 * k + 1);
            prev = v;
        end
        check("write toggles", wq.size() >= 4, 1);
        for (int k = 0; k < 4 && k < wq.size(); k++) check("toggle edge", wq[k], exp[k]);
        check("rw clock in write", ct_tg > 8 && rw_tg - ct_tg <= 3 && ct_tg - rw_tg <= 3, 1);
        check("write current off", write_en, 0);
        $display("write test done");
    endtask

    // Drive one sector on the data head, 75 sys cycles a cell
    task automatic read_frame(input logic [7:0] b, input logic quiet);
        logic prev;
        prev = 1'b1;
        rq.delete();
        eq.delete();
        rw_tg = 0;
        read_gate_n = 1'b0; // Opens ahead of the sync transition, as one cell after write start would
        repeat (10) @(negedge clk_sys);
        sector_track = 1'b1; // Sector mark while reading restarts the oscillator
        repeat (10) @(negedge clk_sys);
        read_flux = ~read_flux;
        for (int i = 0; i < 8; i++) begin
            repeat (37) @(negedge clk_sys);
            if (!quiet && !b[i] && !prev) read_flux = ~read_flux;
            repeat (38) @(negedge clk_sys);
            if (!quiet && b[i]) read_flux = ~read_flux;
            prev = b[i];
        end
        repeat (80) @(negedge clk_sys); // Gate held over a further cell to cover head offset
        read_gate_n = 1'b1;
        sector_track = 1'b0;
        repeat (20) @(negedge clk_sys);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        check("reset outputs", {rw_clk_n, track_origin_n, sector_clk_n, unit_on, write_en}, 5'h1c);
        // Write request while off must not put current on the head
        run_write(1'b1);
        check("refused write", widx, 0);
        power_on();
        power_off();
        power_on();
        // Sector track pulses reach the active-low output
        for (int i = 0; i < 3; i++) begin
            sector_track = 1'b1;
            repeat (8) @(negedge clk_sys);
            check("sector low", sector_clk_n, 0);
            sector_track = 1'b0;
            repeat (8) @(negedge clk_sys);
            check("sector high", sector_clk_n, 1);
        end
        $display("sector clock test done");
        // Gap in the clock track marks the origin
        check("origin idle", track_origin_n, 1);
        bit_run = 1'b0;
        repeat (170) @(negedge clk_sys);
        check("origin on gap", track_origin_n, 0);
        bit_run = 1'b1;
        repeat (25) @(negedge clk_sys);
        check("origin cleared", track_origin_n, 1);
        $display("track origin test done");
        run_write(1'b1);
        check_write(1'b1);
        run_write(1'b0);
        check_write(1'b0);
        // Random sectors decoded with the sync bit stripped
        for (int f = 0; f < 3; f++) begin
            seed = xs(seed);
            read_frame(seed[7:0], 1'b0);
            check("strobes", rq.size() >= 8, 1);
            for (int i = 0; i < 8 && i < rq.size(); i++) begin
                check("read bit", rq[i], seed[i]);
                check("read flag", eq[i], 0);
            end
            check("rw clock in read", rw_tg >= 12, 1);
            $display("read test done");
        end
        // No transition after a zero is a bit error
        read_frame(8'h00, 1'b1);
        check("quiet strobes", rq.size() >= 2, 1);
        if (rq.size() >= 2) check("quiet flags", {rq[0], eq[0], eq[1]}, 3'b001);
        $display("read error test done");
        power_off();
        summarize();
    end
endmodule
